// file: shared/pfic_pkg.sv
// constants of the two-class interrupt controller: APB map, field layout, source numbers.
// assumes a 32-bit APB slave port with 12 address bits decoded locally.
package pfic_pkg;
	// =====================================================================
	// bus geometry
	localparam int ADDR_W    = 12;                // decoded byte-address bits
	localparam int DATA_W    = 32;                // APB data width
	localparam int SRC_W     = 5;                 // width of a source number
	localparam int SOURCE_PRIORITY_LEVEL_W    = 4;                 // width of a priority level
	localparam int SRC_SLOTS = 32;                // slots 0..31, slot 0 never a source
	localparam int SRC_LAST  = 29;                // highest real source number

	// =====================================================================
	// register offsets (byte addresses)
	localparam logic [11:0] OFF_THRESH0   = 12'h000; // normal class threshold
	localparam logic [11:0] OFF_THRESH1   = 12'h004; // fast class threshold
	localparam logic [11:0] OFF_VECTOR0   = 12'h100; // normal class vector word
	localparam logic [11:0] OFF_VECTOR1   = 12'h104; // fast class vector word
	localparam logic [11:0] OFF_PENDING   = 12'h200; // all pending sources
	localparam logic [11:0] OFF_FAST_PEND = 12'h204; // pending sources of the fast class
	localparam logic [11:0] OFF_FEATURES  = 12'h300; // implemented sizes
	localparam logic [4:0]  REQ_REGION    = 5'h08;   // paddr[11:7] of 0x400..0x47C

	// =====================================================================
	// per-source request register fields
	localparam int REQ_SOURCE_PRIORITY_LEVEL_LSB   = 0;            // source_priority_level, 4 bits
	localparam int REQ_TARGET_BIT = 8;            // 1 = fast class
	localparam int REQ_ENABLE_BIT = 16;           // source enable
	localparam int REQ_WE_ENABLE  = 26;           // write strobe for enable
	localparam int REQ_WE_TARGET  = 27;           // write strobe for target
	localparam int REQ_WE_SOURCE_PRIORITY_LEVEL    = 28;           // write strobe for priority
	localparam int REQ_SWCLR_BIT  = 29;           // write 1 clears software request
	localparam int REQ_SWSET_BIT  = 30;           // write 1 raises software request
	localparam int REQ_PEND_BIT   = 31;           // read: source pending

	// =====================================================================
	// vector word fields
	localparam int VEC_INDEX_LSB = 3;             // source index in bits 7:3
	localparam int VEC_BASE_LSB  = 11;            // table base in bits 31:11
	localparam int VEC_BASE_W    = 21;

	// =====================================================================
	// reset values and fixed words
	localparam logic [3:0]  THRESH_RST    = 4'h0;
	localparam logic [3:0]  SOURCE_PRIORITY_LEVEL_RST      = 4'h0;
	localparam logic [20:0] VEC_BASE_RST  = 21'h000000;
	localparam logic [31:0] VALID_SRC     = 32'h3FB9_3FFE; // 1..29 less reserved slots
	localparam logic [31:0] FEATURE_WORD  = 32'h0002_0F1D; // 2 targets, 15 levels, 29 sources

	// =====================================================================
	// source numbers of the request lines
	localparam int SRC_EVENT_FIRST = 1;           // four event-router lines, 1..4
	localparam int SRC_TIMER_FIRST = 5;           // two timer zero counts, 5..6
	localparam int SRC_RTC_INC     = 7;
	localparam int SRC_RTC_ALARM   = 8;
	localparam int SRC_CONV_DONE   = 9;
	localparam int SRC_CARD_ONE    = 10;
	localparam int SRC_CARD_TWO    = 11;
	localparam int SRC_SERIAL_ERR  = 12;
	localparam int SRC_TWO_WIRE    = 13;
	localparam int SRC_AUDIO_IN1   = 16;
	localparam int SRC_AUDIO_IN4   = 19;
	localparam int SRC_AUDIO_OUT1  = 20;
	localparam int SRC_AUDIO_OUT2  = 21;
	localparam int SRC_FLASH       = 23;
	localparam int SRC_DISPLAY     = 24;
	localparam int SRC_GEN_DMA     = 25;
	localparam int SRC_USB_LOW     = 26;
	localparam int SRC_USB_HIGH    = 27;
	localparam int SRC_USB_DMA0    = 28;
	localparam int SRC_USB_DMA1    = 29;
endpackage : pfic_pkg

// file: src/pfic_input_sync.sv
// three-stage synchroniser for a vector of asynchronous request levels.
// assumes each bit is a slow level; a change counts once stages two and three agree.
`timescale 1ns/1ns
module pfic_input_sync #(
	parameter int WIDTH = 32
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_q;   // metastable stage, read by stage2 only
	logic [WIDTH-1:0] stage2_q;
	logic [WIDTH-1:0] stage3_q;
	logic [WIDTH-1:0] held_q;     // accepted level
	logic [WIDTH-1:0] held_d;

	// =====================================================================
	// acceptance: hold the old value while stages disagree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			held_d[i] = (stage2_q[i] == stage3_q[i]) ? stage3_q[i] : held_q[i];
		end
	end

	// =====================================================================
	// sampling chain
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stage1_q <= '0;
			stage2_q <= '0;
			stage3_q <= '0;
			held_q   <= '0;
		end else begin
			stage1_q <= asyncIn;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
			held_q   <= held_d;
		end
	end

	assign syncOut = held_q;
endmodule : pfic_input_sync

// file: src/pfic_source_priority_level_select.sv
// picks the highest-priority eligible source of one class.
// assumes eligibility already folds in enable, request, class and threshold.
`timescale 1ns/1ns
module pfic_source_priority_level_select (
	input  wire logic [31:0]  eligible,   // one bit per source slot
	input  wire logic [127:0] prioFlat,   // 4 bits per slot, slot n at [4n+3:4n]
	output logic      [4:0]   bestIndex,  // 0 when nothing eligible
	output logic              anyEligible
);
	logic [3:0] bestLevel;

	// =====================================================================
	// scan: higher level wins, equal levels go to the lower number
	always_comb begin
		bestIndex   = 5'h00;
		bestLevel   = 4'h0;
		anyEligible = |eligible;
		for (int i = 1; i < 32; i++) begin
			if (eligible[i] && (prioFlat[4*i +: 4] > bestLevel)) begin
				bestIndex = 5'(i);
				bestLevel = prioFlat[4*i +: 4];
			end
		end
	end
endmodule : pfic_source_priority_level_select

// file: src/pfic_top.sv
// two-class interrupt controller: 24 level requests steered to the fast or normal output.
// assumes APB master on the same clock; request lines come from other clock domains.
//
// What this block does
// - 24 inputs, each steerable to fast or normal
// - fast output is OR of fast requests
// - fast class outranks every normal request
// - readable word lists pending fast sources
// - requests are level sensitive, pend while held
// - per-source priority, reassignable while running
// - software request acts like hardware request
// - numbering starts at one, zero never source
// - vector index reads zero when nothing qualifies
// - inputs 1..9: events, timers, clock, converter
// - inputs 12..25: serial, two-wire, audio, flash, display, DMA
// - card lines enter inputs 10 and 11
// - USB low to 26, high to 27
// - USB DMA channels to 28 and 29
// - 4-bit priority, zero disables the source
// - target bit 8 selects fast class
// - vector word: index in 7:3, base above
// - per-class threshold gates nesting requests
`timescale 1ns/1ns
module pfic_top (
	input  wire logic        clock,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// peripheral request lines, active high levels
	input  wire logic [3:0]  eventRouterReq,
	input  wire logic [1:0]  timerZeroReq,
	input  wire logic        rtcIncrementReq,
	input  wire logic        rtcAlarmReq,
	input  wire logic        converterDoneReq,
	input  wire logic        cardInterfaceReqOne,
	input  wire logic        cardInterfaceReqTwo,
	input  wire logic        serialRxErrorReq,
	input  wire logic        twoWireTxDoneReq,
	input  wire logic        audioInputOneReq,
	input  wire logic        audioInputFourReq,
	input  wire logic        audioOutputOneReq,
	input  wire logic        audioOutputTwoReq,
	input  wire logic        flashReq,
	input  wire logic        displayReq,
	input  wire logic        generalDmaEngineReq,
	input  wire logic        usbLowPrioReq,
	input  wire logic        usbHighPrioReq,
	input  wire logic        usbDmaZeroReq,
	input  wire logic        usbDmaOneReq,
	// processor interrupt inputs
	output logic             fiqOut,
	output logic             irqOut
);
	// =====================================================================
	// request wiring
	logic [31:0] rawReq;        // slot-indexed request levels
	logic [31:0] syncReq;       // after the synchroniser

	always_comb begin
		rawReq = 32'h0000_0000;
		rawReq[pfic_pkg::SRC_EVENT_FIRST +: 4] = eventRouterReq;
		rawReq[pfic_pkg::SRC_TIMER_FIRST +: 2] = timerZeroReq;
		rawReq[pfic_pkg::SRC_RTC_INC]    = rtcIncrementReq;
		rawReq[pfic_pkg::SRC_RTC_ALARM]  = rtcAlarmReq;
		rawReq[pfic_pkg::SRC_CONV_DONE]  = converterDoneReq;
		rawReq[pfic_pkg::SRC_CARD_ONE]   = cardInterfaceReqOne;
		rawReq[pfic_pkg::SRC_CARD_TWO]   = cardInterfaceReqTwo;
		rawReq[pfic_pkg::SRC_SERIAL_ERR] = serialRxErrorReq;
		rawReq[pfic_pkg::SRC_TWO_WIRE]   = twoWireTxDoneReq;
		rawReq[pfic_pkg::SRC_AUDIO_IN1]  = audioInputOneReq;
		rawReq[pfic_pkg::SRC_AUDIO_IN4]  = audioInputFourReq;
		rawReq[pfic_pkg::SRC_AUDIO_OUT1] = audioOutputOneReq;
		rawReq[pfic_pkg::SRC_AUDIO_OUT2] = audioOutputTwoReq;
		rawReq[pfic_pkg::SRC_FLASH]      = flashReq;
		rawReq[pfic_pkg::SRC_DISPLAY]    = displayReq;
		rawReq[pfic_pkg::SRC_GEN_DMA]    = generalDmaEngineReq;
		rawReq[pfic_pkg::SRC_USB_LOW]    = usbLowPrioReq;
		rawReq[pfic_pkg::SRC_USB_HIGH]   = usbHighPrioReq;
		rawReq[pfic_pkg::SRC_USB_DMA0]   = usbDmaZeroReq;
		rawReq[pfic_pkg::SRC_USB_DMA1]   = usbDmaOneReq;
	end

	// card lines already follow their own mask logic, so they are taken as plain levels
	pfic_input_sync #(
		.WIDTH   (32)
	) u_sync (
		.clock   (clock),
		.rst     (rst),
		.asyncIn (rawReq),
		.syncOut (syncReq)
	);

	// =====================================================================
	// configuration and status state
	logic [3:0]  source_priority_level_q [32];     // per-slot priority level
	logic [3:0]  source_priority_level_d [32];
	logic [31:0] target_q;        // 1 = fast class
	logic [31:0] target_d;
	logic [31:0] enable_q;        // per-source enable
	logic [31:0] enable_d;
	logic [31:0] swReq_q;         // software-raised requests
	logic [31:0] swReq_d;
	logic [3:0]  thresh0_q;       // normal class threshold
	logic [3:0]  thresh0_d;
	logic [3:0]  thresh1_q;       // fast class threshold
	logic [3:0]  thresh1_d;
	logic [20:0] vecBase0_q;      // normal class table base
	logic [20:0] vecBase0_d;
	logic [20:0] vecBase1_q;      // fast class table base
	logic [20:0] vecBase1_d;
	logic        fiq_q;
	logic        fiq_d;
	logic        irq_q;
	logic        irq_d;
	logic [31:0] rdata_q;         // read data captured in the setup cycle
	logic [31:0] rdata_d;
	logic        err_q;           // unmapped address flag for the access phase
	logic        err_d;

	// =====================================================================
	// bus decode
	logic        setupPhase;      // psel high, penable low
	logic        wrAccess;        // write completes this edge
	logic        inReqRegion;     // paddr in 0x400..0x47C
	logic [4:0]  reqSlot;         // slot addressed in the request region
	logic        reqHit;          // request register for slots 1..29, reserved slots included
	logic        mapped;          // paddr names a register

	assign setupPhase  = psel && !penable;
	assign wrAccess    = psel && penable && pwrite;
	assign inReqRegion = (paddr[11:7] == pfic_pkg::REQ_REGION) && (paddr[1:0] == 2'h0);
	assign reqSlot     = paddr[6:2];
	// slot 0 and slots above 29 have no request register
	assign reqHit      = inReqRegion && (reqSlot != 5'h00) && (reqSlot <= 5'(pfic_pkg::SRC_LAST));
	assign mapped      = reqHit
		|| (paddr == pfic_pkg::OFF_THRESH0)  || (paddr == pfic_pkg::OFF_THRESH1)
		|| (paddr == pfic_pkg::OFF_VECTOR0)  || (paddr == pfic_pkg::OFF_VECTOR1)
		|| (paddr == pfic_pkg::OFF_PENDING)  || (paddr == pfic_pkg::OFF_FAST_PEND)
		|| (paddr == pfic_pkg::OFF_FEATURES);

	// =====================================================================
	// request qualification
	logic [31:0]  active;         // level or software request, real slots only
	logic [31:0]  fastElig;       // candidates for the fast output
	logic [31:0]  normElig;       // candidates for the normal output
	logic [127:0] prioFlat;
	logic [4:0]   fastIndex;
	logic [4:0]   normIndex;
	logic         fastAny;
	logic         normAny;

	always_comb begin
		// pending follows the held level or the software request
		active = (syncReq | swReq_q) & pfic_pkg::VALID_SRC;
		for (int i = 0; i < 32; i++) begin
			prioFlat[4*i +: 4] = source_priority_level_q[i];
			// zero priority disables; only levels above the threshold count
			fastElig[i] = active[i] && enable_q[i] && target_q[i]
				&& (source_priority_level_q[i] != 4'h0) && (source_priority_level_q[i] > thresh1_q);
			normElig[i] = active[i] && enable_q[i] && !target_q[i]
				&& (source_priority_level_q[i] != 4'h0) && (source_priority_level_q[i] > thresh0_q);
		end
	end

	// one selector per class
	pfic_source_priority_level_select u_fastSel (
		.eligible    (fastElig),
		.prioFlat    (prioFlat),
		.bestIndex   (fastIndex),
		.anyEligible (fastAny)
	);

	pfic_source_priority_level_select u_normSel (
		.eligible    (normElig),
		.prioFlat    (prioFlat),
		.bestIndex   (normIndex),
		.anyEligible (normAny)
	);

	// =====================================================================
	// outputs: fast is the OR of its class, normal yields while fast is up
	always_comb begin
		fiq_d = fastAny;
		irq_d = normAny && !fastAny;
	end

	// =====================================================================
	// register writes
	always_comb begin
		source_priority_level_d     = source_priority_level_q;
		target_d   = target_q;
		enable_d   = enable_q;
		swReq_d    = swReq_q;
		thresh0_d  = thresh0_q;
		thresh1_d  = thresh1_q;
		vecBase0_d = vecBase0_q;
		vecBase1_d = vecBase1_q;
		if (wrAccess) begin
			if (reqHit) begin
				// each field changes only under its own write strobe, at any time
				if (pwdata[pfic_pkg::REQ_WE_SOURCE_PRIORITY_LEVEL]) begin
					source_priority_level_d[reqSlot] = pwdata[pfic_pkg::REQ_SOURCE_PRIORITY_LEVEL_LSB +: 4];
				end
				if (pwdata[pfic_pkg::REQ_WE_TARGET]) begin
					target_d[reqSlot] = pwdata[pfic_pkg::REQ_TARGET_BIT];
				end
				if (pwdata[pfic_pkg::REQ_WE_ENABLE]) begin
					enable_d[reqSlot] = pwdata[pfic_pkg::REQ_ENABLE_BIT];
				end
				// set wins when both strobes are written together
				if (pwdata[pfic_pkg::REQ_SWSET_BIT]) begin
					swReq_d[reqSlot] = 1'b1;
				end else if (pwdata[pfic_pkg::REQ_SWCLR_BIT]) begin
					swReq_d[reqSlot] = 1'b0;
				end
			end else begin
				unique case (paddr)
					pfic_pkg::OFF_THRESH0: begin
						thresh0_d = pwdata[3:0];
					end
					pfic_pkg::OFF_THRESH1: begin
						thresh1_d = pwdata[3:0];
					end
					pfic_pkg::OFF_VECTOR0: begin
						vecBase0_d = pwdata[pfic_pkg::VEC_BASE_LSB +: pfic_pkg::VEC_BASE_W];
					end
					pfic_pkg::OFF_VECTOR1: begin
						vecBase1_d = pwdata[pfic_pkg::VEC_BASE_LSB +: pfic_pkg::VEC_BASE_W];
					end
					default: begin
						// read-only or unmapped: write ignored
					end
				endcase
			end
		end
	end

	// =====================================================================
	// read data, captured in the setup cycle so prdata comes from a flop
	always_comb begin
		rdata_d = rdata_q;
		err_d   = err_q;
		if (setupPhase) begin
			err_d   = !mapped;
			rdata_d = 32'h0000_0000;
			if (!pwrite && reqHit) begin
				rdata_d[pfic_pkg::REQ_SOURCE_PRIORITY_LEVEL_LSB +: 4]  = source_priority_level_q[reqSlot];
				rdata_d[pfic_pkg::REQ_TARGET_BIT]     = target_q[reqSlot];
				rdata_d[pfic_pkg::REQ_ENABLE_BIT]     = enable_q[reqSlot];
				rdata_d[pfic_pkg::REQ_SWSET_BIT]      = swReq_q[reqSlot];
				rdata_d[pfic_pkg::REQ_PEND_BIT]       = active[reqSlot];
			end else if (!pwrite) begin
				unique case (paddr)
					pfic_pkg::OFF_THRESH0: begin
						rdata_d[3:0] = thresh0_q;
					end
					pfic_pkg::OFF_THRESH1: begin
						rdata_d[3:0] = thresh1_q;
					end
					pfic_pkg::OFF_VECTOR0: begin
						// index is zero when nothing clears the threshold
						rdata_d[pfic_pkg::VEC_BASE_LSB +: pfic_pkg::VEC_BASE_W] = vecBase0_q;
						rdata_d[pfic_pkg::VEC_INDEX_LSB +: 5] = normIndex;
					end
					pfic_pkg::OFF_VECTOR1: begin
						rdata_d[pfic_pkg::VEC_BASE_LSB +: pfic_pkg::VEC_BASE_W] = vecBase1_q;
						rdata_d[pfic_pkg::VEC_INDEX_LSB +: 5] = fastIndex;
					end
					pfic_pkg::OFF_PENDING: begin
						rdata_d = active;
					end
					pfic_pkg::OFF_FAST_PEND: begin
						rdata_d = active & target_q;
					end
					pfic_pkg::OFF_FEATURES: begin
						rdata_d = pfic_pkg::FEATURE_WORD;
					end
					default: begin
						rdata_d = 32'h0000_0000;                             // unmapped reads zero
					end
				endcase
			end
		end
	end

	// =====================================================================
	// state registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 32; i++) begin
				source_priority_level_q[i] <= pfic_pkg::SOURCE_PRIORITY_LEVEL_RST;
			end
			target_q   <= 32'h0000_0000;
			enable_q   <= 32'h0000_0000;
			swReq_q    <= 32'h0000_0000;
			thresh0_q  <= pfic_pkg::THRESH_RST;
			thresh1_q  <= pfic_pkg::THRESH_RST;
			vecBase0_q <= pfic_pkg::VEC_BASE_RST;
			vecBase1_q <= pfic_pkg::VEC_BASE_RST;
			fiq_q      <= 1'b0;
			irq_q      <= 1'b0;
			rdata_q    <= 32'h0000_0000;
			err_q      <= 1'b0;
		end else begin
			source_priority_level_q     <= source_priority_level_d;
			target_q   <= target_d;
			enable_q   <= enable_d;
			swReq_q    <= swReq_d;
			thresh0_q  <= thresh0_d;
			thresh1_q  <= thresh1_d;
			vecBase0_q <= vecBase0_d;
			vecBase1_q <= vecBase1_d;
			fiq_q      <= fiq_d;
			irq_q      <= irq_d;
			rdata_q    <= rdata_d;
			err_q      <= err_d;
		end
	end

	// =====================================================================
	// port drive; zero wait states keep the bus simple
	assign pready  = 1'b1;
	assign pslverr = psel && penable && err_q;
	assign prdata  = rdata_q;
	assign fiqOut  = fiq_q;
	assign irqOut  = irq_q;
endmodule : pfic_top

// file: verification/pfic_top_sva.sv
// checker of the interrupt controller: bus answers and output qualification.
// assumes it is bound onto pfic_top and sees only its ports.
`timescale 1ns/1ns
module pfic_top_sva (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        fiqOut,
	input wire logic        irqOut
);
	// =====================================================================
	// access-phase decodes
	logic rdAcc; // read in its access phase
	logic wrAcc; // write at its taking edge
	assign rdAcc = psel && penable && !pwrite;
	assign wrAcc = psel && penable && pwrite;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// =====================================================================
	// outputs
	chk_fast_over_normal: assert property (fiqOut |-> !irqOut)
		else $error("normal output high beside fast output");
	chk_quiet_after_reset: assert property ($fell(rst) |-> !fiqOut && !irqOut)
		else $error("output high right after reset");
	// a threshold of 15 leaves no level above it, so the class goes quiet;
	// the output flop still shows the old threshold one edge after the write
	chk_fast_thresh_max: assert property (wrAcc && paddr == pfic_pkg::OFF_THRESH1 && pwdata[3:0] == 4'hF
		|-> ##2 !fiqOut)
		else $error("fast output high above top threshold");
	chk_norm_thresh_max: assert property (wrAcc && paddr == pfic_pkg::OFF_THRESH0 && pwdata[3:0] == 4'hF
		|-> ##2 !irqOut)
		else $error("normal output high above top threshold");

	// =====================================================================
	// read answers
	chk_err_in_access: assert property (pslverr |-> psel && penable)
		else $error("error flag outside access phase");
	chk_unmapped_read: assert property (rdAcc && paddr == 12'h008 |-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	chk_feature_word: assert property (rdAcc && paddr == pfic_pkg::OFF_FEATURES
		|-> prdata == pfic_pkg::FEATURE_WORD)
		else $error("feature word wrong");
	chk_vector_index: assert property (rdAcc && (paddr == pfic_pkg::OFF_VECTOR0 || paddr == pfic_pkg::OFF_VECTOR1)
		|-> prdata[2:0] == 3'h0 && prdata[10:8] == 3'h0
		&& (prdata[7:3] == 5'h00 || pfic_pkg::VALID_SRC[prdata[7:3]]))
		else $error("vector index not a real source");
	chk_pending_real: assert property (rdAcc && (paddr == pfic_pkg::OFF_PENDING || paddr == pfic_pkg::OFF_FAST_PEND)
		|-> (prdata & ~pfic_pkg::VALID_SRC) == 32'h0)
		else $error("pending bit on a reserved slot");
endmodule : pfic_top_sva

bind pfic_top pfic_top_sva chk_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .fiqOut(fiqOut), .irqOut(irqOut));

// file: verification/pfic_cpu_model.sv
// processor-side model: counts entries into fast and normal service.
// assumes level interrupt inputs sampled on the system clock.
`timescale 1ns/1ns
module pfic_cpu_model (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       fiqOut,
	input  wire logic       irqOut,
	output logic      [7:0] fiqEntries_q,
	output logic      [7:0] irqEntries_q
);
	logic [1:0] seen_q;       // levels one edge ago
	logic [1:0] seen_d;
	logic [7:0] fiqEntries_d;
	logic [7:0] irqEntries_d;
	// =====================================================================
	// a rising level is one entry; a held level is not re-entered
	always_comb begin
		seen_d = {fiqOut, irqOut};
		fiqEntries_d = fiqEntries_q + {7'h00, fiqOut && !seen_q[1]};
		irqEntries_d = irqEntries_q + {7'h00, irqOut && !seen_q[0]};
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			seen_q <= 2'h0;
			fiqEntries_q <= 8'h00;
			irqEntries_q <= 8'h00;
		end else begin
			seen_q <= seen_d;
			fiqEntries_q <= fiqEntries_d;
			irqEntries_q <= irqEntries_d;
		end
	end
endmodule : pfic_cpu_model

// file: verification/tb_pfic_top.sv
// testbench of the interrupt controller: APB register access and request lines.
// assumes pfic_pkg compiled first and the checker bound in.
`timescale 1ns/1ns
module tb_pfic_top;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] reqVec = 32'h0;  // bit n drives source n
	logic [31:0] prdata;
	logic [31:0] rdData;
	logic        pready;
	logic        pslverr;
	logic        rdErr;
	logic        fiqOut;
	logic        irqOut;
	logic [7:0]  fiqEntries;
	logic [7:0]  irqEntries;
	int          n_fail = 0;
	int          comparisons = 0;

	always #4 clock = ~clock;

	pfic_top dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.eventRouterReq(reqVec[4:1]), .timerZeroReq(reqVec[6:5]), .rtcIncrementReq(reqVec[7]),
		.rtcAlarmReq(reqVec[8]), .converterDoneReq(reqVec[9]), .cardInterfaceReqOne(reqVec[10]),
		.cardInterfaceReqTwo(reqVec[11]), .serialRxErrorReq(reqVec[12]), .twoWireTxDoneReq(reqVec[13]),
		.audioInputOneReq(reqVec[16]), .audioInputFourReq(reqVec[19]), .audioOutputOneReq(reqVec[20]),
		.audioOutputTwoReq(reqVec[21]), .flashReq(reqVec[23]), .displayReq(reqVec[24]),
		.generalDmaEngineReq(reqVec[25]), .usbLowPrioReq(reqVec[26]), .usbHighPrioReq(reqVec[27]),
		.usbDmaZeroReq(reqVec[28]), .usbDmaOneReq(reqVec[29]), .fiqOut(fiqOut), .irqOut(irqOut));

	pfic_cpu_model cpu_u (.clock(clock), .rst(rst), .fiqOut(fiqOut), .irqOut(irqOut),
		.fiqEntries_q(fiqEntries), .irqEntries_q(irqEntries));

	// =====================================================================
	// bus and compare tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdData, e);
	endtask : rd

	// synchroniser plus output register, with margin
	task automatic settle();
		repeat (8) @(posedge clock);
	endtask : settle

	function automatic logic [11:0] ra(input int n);
		return 12'h400 + 12'(n * 4);
	endfunction : ra

	// priority, target and enable, all three write strobes set
	function automatic logic [31:0] cfg(input logic [3:0] p, input logic t);
		return 32'h1C01_0000 | {23'h0, t, 4'h0, p};
	endfunction : cfg

	task automatic results();
		if (n_fail == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	// =====================================================================
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		results();
	end

	// =====================================================================
	// test sequence
	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rd(pfic_pkg::OFF_FEATURES, pfic_pkg::FEATURE_WORD);
		rd(12'h008, 32'h0);
		chk({31'h0, rdErr}, 32'h1);
		// every slot alone, all sources still disabled
		for (int n = 0; n < 32; n++) begin
			reqVec <= 32'h1 << n;
			settle();
			rd(pfic_pkg::OFF_PENDING, (32'h1 << n) & pfic_pkg::VALID_SRC);
			chk({30'h0, fiqOut, irqOut}, 32'h0);
		end
		reqVec <= 32'h0;
		// card line one steered to the fast class
		apb(1'b1, ra(10), cfg(4'h5, 1'b1));
		reqVec[10] <= 1'b1;
		settle();
		chk({30'h0, fiqOut, irqOut}, 32'h2);
		rd(pfic_pkg::OFF_VECTOR1, 32'h50);
		rd(pfic_pkg::OFF_FAST_PEND, 32'h400);
		rd(ra(10), 32'h8001_0105);
		// normal request waits behind the fast one
		apb(1'b1, ra(26), cfg(4'h9, 1'b0));
		reqVec[26] <= 1'b1;
		settle();
		chk({30'h0, fiqOut, irqOut}, 32'h2);
		rd(pfic_pkg::OFF_VECTOR0, 32'hD0);
		reqVec[10] <= 1'b0;
		settle();
		chk({30'h0, fiqOut, irqOut}, 32'h1);
		// higher level wins, then the threshold hides both
		apb(1'b1, ra(27), cfg(4'hC, 1'b0));
		reqVec[27] <= 1'b1;
		settle();
		rd(pfic_pkg::OFF_VECTOR0, 32'hD8);
		apb(1'b1, pfic_pkg::OFF_THRESH0, 32'hC);
		settle();
		rd(pfic_pkg::OFF_VECTOR0, 32'h0);
		chk({31'h0, irqOut}, 32'h0);
		apb(1'b1, pfic_pkg::OFF_THRESH0, 32'hF);
		apb(1'b1, pfic_pkg::OFF_THRESH0, 32'h0);
		// move a live source to the fast class, target strobe only
		apb(1'b1, ra(27), 32'h0800_0100);
		settle();
		chk({30'h0, fiqOut, irqOut}, 32'h2);
		rd(pfic_pkg::OFF_VECTOR1, 32'hD8);
		// software request on a quiet line
		apb(1'b1, ra(29), 32'h5C01_010F);
		settle();
		rd(pfic_pkg::OFF_VECTOR1, 32'hE8);
		rd(ra(29), 32'hC001_010F);
		apb(1'b1, pfic_pkg::OFF_THRESH1, 32'hF);
		settle();
		chk({30'h0, fiqOut, irqOut}, 32'h1);
		apb(1'b1, pfic_pkg::OFF_THRESH1, 32'h0);
		apb(1'b1, ra(29), 32'h2000_0000);
		// priority zero keeps an enabled, active source out
		apb(1'b1, ra(28), 32'h1C01_0100);
		reqVec[28] <= 1'b1;
		settle();
		rd(pfic_pkg::OFF_VECTOR1, 32'hD8);
		// a reserved slot ignores its software request
		apb(1'b1, ra(14), 32'h5C01_010F);
		settle();
		rd(pfic_pkg::OFF_PENDING, 32'h1C00_0000);
		chk({16'h0, fiqEntries, irqEntries}, 32'h0303);
		results();
	end
endmodule : tb_pfic_top
